// ==== core/uiop_pkg.sv ====
package uiop_pkg;

    // ***********************************************************
    // Register map
    // ***********************************************************
    localparam logic [5:0] UIOP_ADDR_WRITE = 6'h39;
    localparam logic [5:0] UIOP_ADDR_SET = 6'h3A;
    localparam logic [5:0] UIOP_ADDR_CLEAR = 6'h3B;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int UIOP_BIT_RESERVED = 0;
    localparam int UIOP_BIT_SWAP = 1;
    localparam int UIOP_LSB_SERIAL_LEVEL = 2;
    localparam int UIOP_BIT_PULLUP_POS = 4;
    localparam int UIOP_BIT_PULLUP_NEG = 5;
    localparam int UIOP_LSB_BUS_LEVEL = 6;

    // Bits that storage may ever hold; bit 0 is always zero
    localparam logic [7:0] UIOP_WRITABLE_MASK = 8'hFE;

    // ***********************************************************
    // Reset values
    // ***********************************************************
    localparam logic [1:0] UIOP_RESET_SERIAL_LEVEL = 2'h1;
    localparam logic [1:0] UIOP_RESET_BUS_LEVEL = 2'h0;
    localparam logic [7:0] UIOP_RESET_VALUE = 8'h04;

    // ***********************************************************
    // Regulator level codes
    // ***********************************************************
    typedef enum logic [1:0] {
        UIOP_LVL_3V30 = 2'b00,
        UIOP_LVL_3V00 = 2'b01,
        UIOP_LVL_2V75 = 2'b10,
        UIOP_LVL_2V50 = 2'b11
    } uiop_level_t;

    // ***********************************************************
    // Operating modes of the transceiver
    // ***********************************************************
    typedef enum logic [2:0] {
        UIOP_MODE_SYNC = 3'b000,
        UIOP_MODE_SERIAL = 3'b001,
        UIOP_MODE_LOW_POWER = 3'b010,
        UIOP_MODE_UART = 3'b011,
        UIOP_MODE_AUDIO_FN = 3'b100,
        UIOP_MODE_HEADSET = 3'b101
    } uiop_mode_t;

endpackage

// ==== core/uiop_route.sv ====
`timescale 1ns/100ps

// ***************************************************************
// Pin routing and pull-up selection, purely combinational
// ***************************************************************
module uiop_route
    import uiop_pkg::*;
(
    // Control
    input wire logic line_pair_swap,
    input wire logic in_audio_fn,
    input wire logic in_headset,
    input wire logic in_uart,
    input wire logic pullup_pos_en,
    input wire logic pullup_neg_en,
    // Core-side line signals
    input wire logic core_pos_line,
    input wire logic core_neg_line,
    input wire logic core_left_speaker,
    input wire logic core_right_mono_speaker,
    // Pin-side signals
    output logic pin_pos_line,
    output logic pin_neg_line,
    output logic left_speaker_pin,
    output logic right_mono_speaker_pin,
    output logic charger_pullup_pos_line,
    output logic charger_pullup_neg_line
);

    // Swap covers data and audio-function routing; speakers never swap
    always_comb begin
        if (line_pair_swap) begin
            pin_pos_line = core_neg_line;
            pin_neg_line = core_pos_line;
        end else begin
            pin_pos_line = core_pos_line;
            pin_neg_line = core_neg_line;
        end
        left_speaker_pin = core_left_speaker;
        right_mono_speaker_pin = core_right_mono_speaker;
        // Pull-ups forced on in serial-line mode
        charger_pullup_pos_line = pullup_pos_en | in_uart;
        charger_pullup_neg_line = pullup_neg_en | in_uart;
    end

    // Audio-function and headset flags only document intent here
    logic unused_modes;
    assign unused_modes = in_audio_fn & in_headset;

endmodule

// ==== core/uiop_regs.sv ====
`timescale 1ns/100ps

module uiop_regs
    import uiop_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register access from the ULPI command decoder
    input wire logic reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Operating mode and transmit enable from the PHY core
    input wire uiop_pkg::uiop_mode_t op_mode,
    input wire logic transmit_line_enable,
    // Core-side line signals
    input wire logic core_pos_line,
    input wire logic core_neg_line,
    input wire logic core_left_speaker,
    input wire logic core_right_mono_speaker,
    // Pin-side outputs
    output logic pin_pos_line,
    output logic pin_neg_line,
    output logic left_speaker_pin,
    output logic right_mono_speaker_pin,
    output logic charger_pullup_pos_line,
    output logic charger_pullup_neg_line,
    // Regulator control
    output uiop_pkg::uiop_level_t regulated_supply_output
);
    import uiop_pkg::*;

    // ***********************************************************
    // Register storage
    // ***********************************************************
    // Stored byte; bit 0 never holds a one
    logic [7:0] io_power_management_q;
    logic [7:0] io_power_management_d;
    // Regulator state
    uiop_level_t level_q;
    uiop_level_t level_d;
    logic uart_armed_q;
    logic uart_armed_d;

    // ***********************************************************
    // Address decode
    // ***********************************************************
    // Address matches any of the three aliases; anything else in the
    // vendor range belongs to a neighbouring register
    function automatic logic addr_in_alias(input logic [5:0] a);
        addr_in_alias = (a == UIOP_ADDR_WRITE) || (a == UIOP_ADDR_SET) ||
            (a == UIOP_ADDR_CLEAR);
    endfunction

    // Two-bit level field at a given position of the stored byte
    function automatic uiop_level_t field_level(input logic [7:0] r,
        input int lsb);
        field_level = uiop_level_t'(r[lsb +: 2]);
    endfunction

    // Decode of all three aliases; each reads the same contents
    // Other addresses read zero so a neighbour's data can be ORed in
    always_comb begin
        reg_hit = addr_in_alias(reg_addr);
        reg_rdata = reg_hit ? io_power_management_q : 8'h00;
    end

    // ***********************************************************
    // Alias update
    // ***********************************************************
    // Set and clear change single bits without a read first, which
    // saves the link a full register round trip per bit
    // Write, set and clear aliases; bit 0 stays zero
    always_comb begin
        io_power_management_d = io_power_management_q;
        if (reg_wr) begin
            unique case (reg_addr)
                UIOP_ADDR_WRITE: io_power_management_d = reg_wdata;
                UIOP_ADDR_SET:
                    io_power_management_d =
                        io_power_management_q | reg_wdata;
                UIOP_ADDR_CLEAR:
                    io_power_management_d =
                        io_power_management_q & ~reg_wdata;
                default: io_power_management_d = io_power_management_q;
            endcase
        end
        io_power_management_d =
            io_power_management_d & UIOP_WRITABLE_MASK;
    end

    // ***********************************************************
    // Regulator level selection
    // ***********************************************************
    // Decoded mode flags
    logic in_uart;
    logic in_headset;
    logic in_audio_fn;
    // Level fields as stored
    uiop_level_t serial_mode_regulator_level;
    uiop_level_t bus_mode_regulator_level;

    // Mode flags; codes 6 and 7 are never sent by the core and raise
    // no flag, so the supply then follows the bus field like USB modes
    always_comb begin
        in_uart = 1'b0;
        in_headset = 1'b0;
        in_audio_fn = 1'b0;
        unique case (op_mode)
            UIOP_MODE_SYNC, UIOP_MODE_SERIAL, UIOP_MODE_LOW_POWER: begin
                in_uart = 1'b0;
            end
            UIOP_MODE_UART: begin
                in_uart = 1'b1;
            end
            UIOP_MODE_AUDIO_FN: begin
                in_audio_fn = 1'b1;
            end
            UIOP_MODE_HEADSET: begin
                in_headset = 1'b1;
            end
            default: begin
                in_uart = 1'b0;
            end
        endcase
    end

    assign serial_mode_regulator_level =
        field_level(io_power_management_q, UIOP_LSB_SERIAL_LEVEL);
    assign bus_mode_regulator_level =
        field_level(io_power_management_q, UIOP_LSB_BUS_LEVEL);

    // UART level waits for transmit enable so the supply does not step
    // before the link has actually moved the lines over
    always_comb begin
        uart_armed_d = uart_armed_q;
        level_d = level_q;
        if (in_headset) begin
            level_d = UIOP_LVL_3V30;
            uart_armed_d = 1'b0;
        end else if (in_uart) begin
            if (transmit_line_enable) begin
                uart_armed_d = 1'b1;
            end
            if (uart_armed_q || transmit_line_enable) begin
                level_d = serial_mode_regulator_level;
            end
        end else begin
            // Audio function mode lands here too: the bus field still
            // rules the supply, as no separate level applies to it
            uart_armed_d = 1'b0;
            level_d = bus_mode_regulator_level;
        end
    end

    // Synchronous reset restores defaults, swap bit cleared
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            io_power_management_q <= UIOP_RESET_VALUE;
        end else begin
            io_power_management_q <= io_power_management_d;
        end
    end

    // Regulator state; reset starts at the bus field's default, which is
    // what the stored byte selects right after reset as well
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            level_q <= uiop_level_t'(UIOP_RESET_BUS_LEVEL);
            uart_armed_q <= 1'b0;
        end else begin
            level_q <= level_d;
            uart_armed_q <= uart_armed_d;
        end
    end

    // ***********************************************************
    // Regulator output
    // ***********************************************************
    // Registered so the supply code never glitches while modes change
    assign regulated_supply_output = level_q;

    // ***********************************************************
    // Pin routing
    // ***********************************************************
    uiop_route u_route (
        .line_pair_swap(io_power_management_q[UIOP_BIT_SWAP]),
        .in_audio_fn(in_audio_fn),
        .in_headset(in_headset),
        .in_uart(in_uart),
        .pullup_pos_en(io_power_management_q[UIOP_BIT_PULLUP_POS]),
        .pullup_neg_en(io_power_management_q[UIOP_BIT_PULLUP_NEG]),
        .core_pos_line(core_pos_line),
        .core_neg_line(core_neg_line),
        .core_left_speaker(core_left_speaker),
        .core_right_mono_speaker(core_right_mono_speaker),
        .pin_pos_line(pin_pos_line),
        .pin_neg_line(pin_neg_line),
        .left_speaker_pin(left_speaker_pin),
        .right_mono_speaker_pin(right_mono_speaker_pin),
        .charger_pullup_pos_line(charger_pullup_pos_line),
        .charger_pullup_neg_line(charger_pullup_neg_line)
    );

endmodule

// ==== verification/uiop_regs_checker.sv ====
`timescale 1ns/100ps
// ************************************************
// Port-level checks of the register block
// ************************************************
module uiop_regs_checker
    import uiop_pkg::*;
(
    // Clock, reset and register port
    input wire logic clock,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_hit,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Mode and line signals
    input wire uiop_pkg::uiop_mode_t op_mode,
    input wire logic transmit_line_enable,
    input wire logic core_pos_line,
    input wire logic core_neg_line,
    input wire logic core_left_speaker,
    input wire logic core_right_mono_speaker,
    input wire logic pin_pos_line,
    input wire logic pin_neg_line,
    input wire logic left_speaker_pin,
    input wire logic right_mono_speaker_pin,
    input wire logic charger_pullup_pos_line,
    input wire logic charger_pullup_neg_line,
    input wire uiop_pkg::uiop_level_t regulated_supply_output
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Serial level applies only once the transmit enable was seen
    sequence s_tx_seen;
        op_mode == UIOP_MODE_UART && transmit_line_enable;
    endsequence
    sequence s_uart_still;
        (op_mode == UIOP_MODE_UART && reg_hit) [*2];
    endsequence
    // A set or clear write, then the alias still addressed for read-back
    sequence s_set_wr;
        reg_wr && reg_addr == UIOP_ADDR_SET ##1 reg_hit;
    endsequence
    sequence s_clear_wr;
        reg_wr && reg_addr == UIOP_ADDR_CLEAR ##1 reg_hit;
    endsequence
    a_set_alias: assert property (s_set_wr |->
        reg_rdata == ($past(reg_rdata) |
        ($past(reg_wdata) & UIOP_WRITABLE_MASK)))
        else $error("set alias lost bits");
    a_clear_alias: assert property (s_clear_wr |->
        reg_rdata == ($past(reg_rdata) & ~$past(reg_wdata)))
        else $error("clear alias wrong");
    a_pin_swap: assert property (reg_hit |->
        {pin_pos_line, pin_neg_line} == (reg_rdata[1] ?
        {core_neg_line, core_pos_line} : {core_pos_line, core_neg_line}))
        else $error("line pair routing wrong");
    a_speaker_pass: assert property (op_mode == UIOP_MODE_HEADSET |->
        {left_speaker_pin, right_mono_speaker_pin} ==
        {core_left_speaker, core_right_mono_speaker})
        else $error("speaker moved");
    a_pull_uart: assert property (op_mode == UIOP_MODE_UART |->
        charger_pullup_pos_line && charger_pullup_neg_line)
        else $error("no pull");
    a_pull_bits: assert property (reg_hit &&
        op_mode != UIOP_MODE_UART |->
        {charger_pullup_pos_line, charger_pullup_neg_line} ==
        {reg_rdata[4], reg_rdata[5]}) else $error("pull-up bits wrong");
    a_headset_level: assert property (op_mode == UIOP_MODE_HEADSET |=>
        regulated_supply_output == UIOP_LVL_3V30)
        else $error("headset level");
    a_bus_level: assert property (reg_hit &&
        op_mode inside {UIOP_MODE_SYNC, UIOP_MODE_SERIAL, UIOP_MODE_LOW_POWER}
        |=> regulated_supply_output == $past(reg_rdata[7:6]))
        else $error("bus level wrong");
    a_uart_level: assert property (s_tx_seen ##1
        s_uart_still |=> regulated_supply_output == $past(reg_rdata[3:2]))
        else $error("uart level");
endmodule
bind uiop_regs uiop_regs_checker i_chk (.*);

// ==== verification/uiop_link.sv ====
`timescale 1ns/100ps
// ************************************************
// Link-side source of register commands
// ************************************************
module uiop_link (
    // Clock in, register command out
    input wire logic clock,
    output logic reg_wr,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle data is inverted so a stale byte never passes for a fresh one
    initial begin
        reg_wr = 1'b0;
        reg_addr = 6'h39;
        reg_wdata = 8'h00;
    end
    // Immediate write: strobe held across exactly one rising edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Immediate read: address only, data comes back combinationally
    task automatic rd(input logic [5:0] a);
        @(negedge clock);
        reg_addr = a;
    endtask
endmodule

// ==== verification/uiop_regs_bench.sv ====
`timescale 1ns/100ps
// ************************************************
// Self-checking bench of the register block
// ************************************************
module uiop_regs_bench;
    import uiop_pkg::*;
    logic clock, rst_b, reg_wr, reg_hit, transmit_line_enable;
    logic core_pos_line, core_neg_line, core_left_speaker;
    logic core_right_mono_speaker, pin_pos_line, pin_neg_line;
    logic left_speaker_pin, right_mono_speaker_pin;
    logic charger_pullup_pos_line, charger_pullup_neg_line;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    uiop_mode_t op_mode;
    uiop_level_t regulated_supply_output;
    int num_errors, checked, m;
    logic [15:0] rnd = 16'h72F7;
    uiop_regs i_dut (.*);
    uiop_link i_link (.*);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic stop_test();
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Settle in a mode, then compare the regulator code
    task automatic lvl(input uiop_mode_t md, input logic te, input int e);
        @(negedge clock);
        op_mode = md;
        transmit_line_enable = te;
        repeat (3) @(negedge clock);
        chk({6'h00, regulated_supply_output}, 8'(e));
    endtask
    // Sweep 38h..3Ch: only the three aliases answer, with defaults
    task automatic after_reset();
        m = 4;
        for (int a = 'h38; a <= 'h3C; a++) begin
            i_link.rd(6'(a));
            #1;
            chk(reg_rdata,
                (a > 'h38 && a < 'h3C) ? UIOP_RESET_VALUE : 8'h00);
            chk({7'h00, reg_hit}, 8'(a > 'h38 && a < 'h3C));
        end
        chk({6'h00, regulated_supply_output}, 8'h00);
    endtask
    // Random write to any alias or a neighbour, then read back
    task automatic op();
        logic [5:0] a;
        logic [7:0] d;
        logic [3:0] c;
        rnd = nxt(rnd);
        a = 6'h38 + 6'(rnd[2:0] % 5);
        d = rnd[15:8];
        i_link.wr(a, d);
        if (a == 6'h39) m = d & 8'hFE;
        if (a == 6'h3A) m = m | (d & 8'hFE);
        if (a == 6'h3B) m = m & ~d;
        rnd = nxt(rnd);
        c = rnd[11:8];
        op_mode = uiop_mode_t'(3'(rnd[7:5] % 6));
        {core_pos_line, core_neg_line, core_left_speaker,
            core_right_mono_speaker} = c;
        i_link.rd(6'h39 + 6'(rnd[1:0] % 3));
        #1;
        chk(reg_rdata, 8'(m));
        chk({4'h0, pin_pos_line, pin_neg_line,
            left_speaker_pin, right_mono_speaker_pin},
            {4'h0, m[1] ? {c[2], c[3], c[1:0]} : c});
        chk({6'h00, charger_pullup_pos_line,
            charger_pullup_neg_line},
            op_mode == UIOP_MODE_UART ? 8'h03 : {6'h00, m[4], m[5]});
    endtask
    initial begin
        rst_b = 1'b0;
        transmit_line_enable = 1'b0;
        op_mode = UIOP_MODE_SYNC;
        {core_pos_line, core_neg_line, core_left_speaker} = 3'h0;
        core_right_mono_speaker = 1'b0;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        after_reset();
        repeat (60) op();
        // Every level code in both fields, bus modes and serial mode
        for (int k = 0; k < 4; k++) begin
            m = k * 64 + (3 - k) * 4;
            i_link.wr(6'h39, 8'(m));
            lvl(uiop_mode_t'(k % 3), 1'b0, m / 64);
            lvl(UIOP_MODE_UART, 1'b1, (m / 4) % 4);
            lvl(UIOP_MODE_SYNC, 1'b0, m / 64);
        end
        lvl(UIOP_MODE_UART, 1'b0, 3);
        lvl(UIOP_MODE_HEADSET, 1'b0, 0);
        // Leave the mode through a mid-run reset
        @(negedge clock);
        rst_b = 1'b0;
        op_mode = UIOP_MODE_SYNC;
        @(negedge clock);
        rst_b = 1'b1;
        after_reset();
        stop_test();
    end
    // Watchdog: the run needs about 260 cycles
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule
